// ---- rsh_map.svh ----
// register offsets, field positions and reset values for the switchover/holdover block
`ifndef RSH_MAP_SVH
`define RSH_MAP_SVH
`define RSH_ADDR_CTRL 8'h00
`define RSH_ADDR_STAT 8'h04
`define RSH_ADDR_IRQ 8'h08
`define RSH_ADDR_MASK 8'h0C
`define RSH_ADDR_FTW 8'h10
// control register fields
`define RSH_C_AUTO_REF 8
`define RSH_C_REF_OVRD 7
`define RSH_C_REF_FORCE 6
`define RSH_C_AUTO_HOLD 5
`define RSH_C_HOLD_OVRD 4
`define RSH_C_HOLD_FORCE 3
`define RSH_C_LINE_CARD 2
`define RSH_C_AUTO_ENTRY 1
`define RSH_C_AUTO_EXIT 0
`define RSH_CTRL_W 9
`define RSH_CTRL_RST 9'h000
// event bits
`define RSH_EV_SWITCH 0
`define RSH_EV_HOLD_IN 1
`define RSH_EV_HOLD_OUT 2
`define RSH_EV_FAIL 3
`define RSH_EV_W 4
`define RSH_EV_RST 4'h0
`endif

// ---- rsh_pkg.sv ----
// types shared by the switchover/holdover block
package rsh_pkg;
    typedef enum logic [1:0] {RSH_ST_A_RUN, RSH_ST_B_RUN, RSH_ST_A_HOLD, RSH_ST_B_HOLD} rsh_state_e;
    typedef struct packed {
        logic auto_ref;
        logic ref_ovrd;
        logic ref_force;
        logic auto_hold;
        logic hold_ovrd;
        logic hold_force;
        logic line_card;
        logic auto_entry;
        logic auto_exit;
    } rsh_ctrl_s;
    typedef struct packed {
        logic a_failed;
        logic b_failed;
        logic a_valid;
        logic b_valid;
    } rsh_mon_s;
endpackage : rsh_pkg

// ---- rsh_sync.sv ----
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module rsh_sync #(
    parameter int W = 2
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // level in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    // first stage feeds only the second
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s1_r <= '0;
            s2_r <= '0;
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule : rsh_sync

// ---- rsh_edge_switch.sv ----
// edge-aligned reference multiplexer control
`timescale 1ns/1ps
module rsh_edge_switch (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic line_card,
    input wire logic want_b,
    // reference rising-edge pulses (already in sys_clk domain)
    input wire logic rise_a,
    input wire logic rise_b,
    // result
    output logic sel_b,
    output logic switched
);
    logic sel_r;
    logic sel_nxt;
    logic sw_r;
    logic sw_nxt;

    // pick when the active reference may change
    always_comb
    begin
        sel_nxt = sel_r;
        sw_nxt = 1'b0;
        if (want_b != sel_r)
        begin
            if (!line_card)
                sel_nxt = want_b;
            else if (want_b ? rise_b : rise_a)
                sel_nxt = want_b;
        end
        sw_nxt = (sel_nxt != sel_r);
    end

    // register selection
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sel_r <= 1'b0;
            sw_r <= 1'b0;
        end
        else
        begin
            sel_r <= sel_nxt;
            sw_r <= sw_nxt;
        end
    end
    assign sel_b = sel_r;
    assign switched = sw_r;
endmodule : rsh_edge_switch

// ---- rsh_ctrl.sv ----
// reference switchover and holdover controller with wishbone registers
// Summary of operation
// - line card off: switch to commanded reference at once
// - line card on: switch only at next rising edge of alternate reference
// - holdover entry freezes tuning word, no phase step
// - in holdover the DDS takes the static tuning word, not the loop word
// - auto-hold bit: 0 manual holdover, 1 state machine holdover
// - manual holdover: pin is input, 1 holdover, 0 normal
// - auto holdover: device drives pin with state machine decision
// - in auto holdover, hold override forces holdover to the force-value bit
// - under hold override the pin still shows state machine decision
// - auto-hold, hold override and force value reset to 0
// - four states: A run, B run, A hold, B hold
// - transitions follow control bits, pins and failure events
// - muxes pick state machine, pin or override for applied signals
// - in auto mode state machine outputs drive the pins
// - manual ref mode pin is input; auto mode pin shows chosen reference
// - ref override uses forced choice bit; in auto mode pin still shows machine choice
// - a reference is selectable again only once validated
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "rsh_map.svh"
module rsh_ctrl import rsh_pkg::*; #(
    parameter int FTW_W = 48
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // reference monitors
    input wire rsh_mon_s mon,
    input wire logic reference_a_input,
    input wire logic reference_b_input,
    // reference choice pin
    input wire logic ref_choice_pin_i,
    output logic ref_choice_pin_o,
    output logic ref_choice_pin_oe,
    // holdover pin
    input wire logic hold_pin_i,
    output logic hold_pin_o,
    output logic hold_pin_oe,
    // loop and DDS
    input wire logic [FTW_W-1:0] loop_ftw,
    output logic [FTW_W-1:0] dds_ftw,
    output logic active_ref_b,
    output logic in_holdover,
    // interrupt
    output logic irq
);
    rsh_ctrl_s ctrl_r, ctrl_nxt;
    rsh_state_e st_r, st_nxt;
    logic [`RSH_EV_W-1:0] stat_r, stat_nxt;
    logic [`RSH_EV_W-1:0] mask_r, mask_nxt;
    logic [FTW_W-1:0] hold_ftw_r, hold_ftw_nxt;
    logic [FTW_W-1:0] ftw_r, ftw_nxt;
    logic [31:0] rd_nxt, rd_r;
    logic ack_r, ack_nxt;
    logic irq_r, irq_nxt;
    logic rp_o_r, rp_oe_r, hp_o_r, hp_oe_r, act_b_r, hold_r;
    logic rp_o_nxt, rp_oe_nxt, hp_o_nxt, hp_oe_nxt, hold_nxt;
    logic [1:0] pins_s;
    logic [1:0] refs_s;
    logic [1:0] refs_d_r;
    logic rise_a, rise_b;
    logic want_b, sel_b, switched;
    logic sm_b, sm_hold;
    logic [`RSH_EV_W-1:0] ev;
    logic fail_lvl, fail_r;
    logic req, wr, rd;

    // pins and reference clocks brought into sys_clk
    rsh_sync #(.W(2)) u_pin_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d({hold_pin_i, ref_choice_pin_i}),
        .q(pins_s)
    );
    rsh_sync #(.W(2)) u_ref_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d({reference_b_input, reference_a_input}),
        .q(refs_s)
    );
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            refs_d_r <= 2'h0;
        else
            refs_d_r <= refs_s;
    end
    assign rise_a = refs_s[0] & ~refs_d_r[0];
    assign rise_b = refs_s[1] & ~refs_d_r[1];

    // state machine decoding
    assign sm_b = (st_r == RSH_ST_B_RUN) || (st_r == RSH_ST_B_HOLD);
    assign sm_hold = (st_r == RSH_ST_A_HOLD) || (st_r == RSH_ST_B_HOLD);

    // next state of the selection/holdover machine
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            RSH_ST_A_RUN:
            begin
                if (!ctrl_r.auto_ref && pins_s[0])
                    st_nxt = RSH_ST_B_RUN;
                else if (ctrl_r.auto_ref && mon.a_failed && mon.b_valid && !mon.b_failed)
                    st_nxt = RSH_ST_B_RUN;
                else if (ctrl_r.auto_hold && ctrl_r.auto_entry && mon.a_failed)
                    st_nxt = RSH_ST_A_HOLD;
                else if (!ctrl_r.auto_hold && pins_s[1])
                    st_nxt = RSH_ST_A_HOLD;
            end
            RSH_ST_B_RUN:
            begin
                if (!ctrl_r.auto_ref && !pins_s[0])
                    st_nxt = RSH_ST_A_RUN;
                else if (ctrl_r.auto_ref && mon.b_failed && mon.a_valid && !mon.a_failed)
                    st_nxt = RSH_ST_A_RUN;
                else if (ctrl_r.auto_hold && ctrl_r.auto_entry && mon.b_failed)
                    st_nxt = RSH_ST_B_HOLD;
                else if (!ctrl_r.auto_hold && pins_s[1])
                    st_nxt = RSH_ST_B_HOLD;
            end
            RSH_ST_A_HOLD:
            begin
                if (!ctrl_r.auto_hold)
                begin
                    if (!pins_s[1])
                        st_nxt = RSH_ST_A_RUN;
                end
                else if (ctrl_r.auto_exit && mon.a_valid && !mon.a_failed)
                    st_nxt = RSH_ST_A_RUN;
                else if (ctrl_r.auto_exit && ctrl_r.auto_ref && mon.b_valid && !mon.b_failed)
                    st_nxt = RSH_ST_B_RUN;
            end
            RSH_ST_B_HOLD:
            begin
                if (!ctrl_r.auto_hold)
                begin
                    if (!pins_s[1])
                        st_nxt = RSH_ST_B_RUN;
                end
                else if (ctrl_r.auto_exit && mon.b_valid && !mon.b_failed)
                    st_nxt = RSH_ST_B_RUN;
                else if (ctrl_r.auto_exit && ctrl_r.auto_ref && mon.a_valid && !mon.a_failed)
                    st_nxt = RSH_ST_A_RUN;
            end
            default: st_nxt = RSH_ST_A_RUN;
        endcase
    end

    // muxes that choose the applied reference and holdover
    always_comb
    begin
        want_b = ctrl_r.auto_ref ? sm_b : pins_s[0];
        if (ctrl_r.ref_ovrd)
            want_b = ctrl_r.ref_force;
        hold_nxt = ctrl_r.auto_hold ? sm_hold : pins_s[1];
        if (ctrl_r.auto_hold && ctrl_r.hold_ovrd)
            hold_nxt = ctrl_r.hold_force;
        rp_oe_nxt = ctrl_r.auto_ref;
        rp_o_nxt = ctrl_r.auto_ref & sm_b;
        hp_oe_nxt = ctrl_r.auto_hold;
        hp_o_nxt = ctrl_r.auto_hold & sm_hold;
    end

    rsh_edge_switch u_switch (
        .sys_clk(sys_clk),
        .rst(rst),
        .line_card(ctrl_r.line_card),
        .want_b(want_b),
        .rise_a(rise_a),
        .rise_b(rise_b),
        .sel_b(sel_b),
        .switched(switched)
    );

    // tuning word: track loop, freeze on holdover entry
    always_comb
    begin
        ftw_nxt = loop_ftw;
        if (hold_nxt && !hold_r)
            ftw_nxt = ftw_r;
        else if (hold_nxt)
            ftw_nxt = hold_ftw_r;
    end

    // events and bus access
    assign ev[`RSH_EV_SWITCH] = switched;
    assign ev[`RSH_EV_HOLD_IN] = hold_nxt & ~hold_r;
    assign ev[`RSH_EV_HOLD_OUT] = ~hold_nxt & hold_r;
    // failure of the active reference counts once, when it starts
    assign fail_lvl = (mon.a_failed & ~sel_b) | (mon.b_failed & sel_b);
    assign ev[`RSH_EV_FAIL] = fail_lvl & ~fail_r;
    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wr = req & wb_we_i;
    assign rd = req & ~wb_we_i;

    // register file next values
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        hold_ftw_nxt = hold_ftw_r;
        stat_nxt = stat_r;
        rd_nxt = 32'h0000_0000;
        if (hold_nxt && !hold_r)
            hold_ftw_nxt = ftw_r;
        if (rd && wb_adr_i == `RSH_ADDR_IRQ)
            stat_nxt = '0;
        stat_nxt = stat_nxt | ev; // set wins over read clear
        if (wr && wb_adr_i == `RSH_ADDR_CTRL)
        begin
            if (wb_sel_i[0])
                ctrl_nxt[`RSH_C_AUTO_REF-1:0] = wb_dat_i[`RSH_C_AUTO_REF-1:0];
            if (wb_sel_i[1])
                ctrl_nxt[`RSH_C_AUTO_REF] = wb_dat_i[`RSH_C_AUTO_REF];
        end
        else if (wr && wb_adr_i == `RSH_ADDR_MASK && wb_sel_i[0])
            mask_nxt = wb_dat_i[`RSH_EV_W-1:0];
        else if (wr && wb_adr_i == `RSH_ADDR_FTW && hold_r)
            hold_ftw_nxt = FTW_W'({hold_ftw_r[FTW_W-1:32], wb_dat_i}); // low word only
        if (wb_adr_i == `RSH_ADDR_CTRL)
            rd_nxt = {23'h0, ctrl_r};
        else if (wb_adr_i == `RSH_ADDR_STAT)
            rd_nxt = {26'h0, st_r, in_holdover, active_ref_b, hp_o_r, rp_o_r};
        else if (wb_adr_i == `RSH_ADDR_IRQ)
            rd_nxt = {28'h0, stat_r};
        else if (wb_adr_i == `RSH_ADDR_MASK)
            rd_nxt = {28'h0, mask_r};
        else if (wb_adr_i == `RSH_ADDR_FTW)
            rd_nxt = hold_ftw_r[31:0];
        ack_nxt = req;
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    // all registers except refs_d_r
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_r <= `RSH_CTRL_RST;
            st_r <= RSH_ST_A_RUN;
            stat_r <= `RSH_EV_RST;
            mask_r <= `RSH_EV_RST;
            hold_ftw_r <= '0;
            ftw_r <= '0;
            rd_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            irq_r <= 1'b0;
            rp_o_r <= 1'b0;
            rp_oe_r <= 1'b0;
            hp_o_r <= 1'b0;
            hp_oe_r <= 1'b0;
            act_b_r <= 1'b0;
            hold_r <= 1'b0;
            fail_r <= 1'b0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            st_r <= st_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            hold_ftw_r <= hold_ftw_nxt;
            ftw_r <= ftw_nxt;
            rd_r <= rd_nxt;
            ack_r <= ack_nxt;
            irq_r <= irq_nxt;
            rp_o_r <= rp_o_nxt;
            rp_oe_r <= rp_oe_nxt;
            hp_o_r <= hp_o_nxt;
            hp_oe_r <= hp_oe_nxt;
            act_b_r <= sel_b;
            hold_r <= hold_nxt;
            fail_r <= fail_lvl;
        end
    end

    assign wb_dat_o = rd_r;
    assign wb_ack_o = ack_r;
    assign irq = irq_r;
    assign ref_choice_pin_o = rp_o_r;
    assign ref_choice_pin_oe = rp_oe_r;
    assign hold_pin_o = hp_o_r;
    assign hold_pin_oe = hp_oe_r;
    assign dds_ftw = ftw_r;
    assign active_ref_b = act_b_r;
    assign in_holdover = hold_r;
endmodule : rsh_ctrl

// ---- rsh_ref_src.sv ----
// reference clock sources that stand still while stopped
`timescale 1ns/1ps
module rsh_ref_src (
    // clock
    input wire logic sys_clk,
    // run enables
    input wire logic run_a,
    input wire logic run_b,
    // reference clocks
    output logic ref_a,
    output logic ref_b
);
    logic [3:0] cnt = 4'h0;
    initial ref_a = 1'b0;
    initial ref_b = 1'b0;
    // a divides by 8, b runs irregularly so edges drift apart
    always @(posedge sys_clk)
    begin
        cnt <= cnt + 4'h1;
        if (run_a)
            ref_a <= ~cnt[2];
        if (run_b)
            ref_b <= (cnt % 4'h6) < 4'h3;
    end
endmodule : rsh_ref_src

// ---- rsh_ctrl_chk.sv ----
// port assertions for the switchover/holdover controller
`timescale 1ns/1ps
module rsh_ctrl_chk #(
    parameter int FTW_W = 48
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bus
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    // pins
    input wire logic ref_choice_pin_i,
    input wire logic ref_choice_pin_oe,
    input wire logic hold_pin_i,
    input wire logic hold_pin_oe,
    // tuning and status
    input wire logic [FTW_W-1:0] loop_ftw,
    input wire logic [FTW_W-1:0] dds_ftw,
    input wire logic active_ref_b,
    input wire logic in_holdover,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_ack_resp;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("request not answered");
    property p_no_stray;
        !wb_stb_i |=> !wb_ack_o;
    endproperty
    a_no_stray: assert property (p_no_stray) else $error("ack without request");
    property p_reset_out;
        $fell(rst) |-> !ref_choice_pin_oe && !hold_pin_oe && !in_holdover && !active_ref_b && !irq;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not idle at reset");
    property p_frozen;
        in_holdover && $past(in_holdover) && !$past(wb_stb_i) && !$past(wb_stb_i, 2)
            |-> $stable(dds_ftw);
    endproperty
    a_frozen: assert property (p_frozen) else $error("holdover word moved");
    property p_track;
        (!in_holdover && $stable(loop_ftw))[*3] |-> dds_ftw == loop_ftw;
    endproperty
    a_track: assert property (p_track) else $error("dds word not from loop");
    property p_hold_man;
        (!hold_pin_oe && $stable(hold_pin_i))[*6] |-> in_holdover == hold_pin_i;
    endproperty
    a_hold_man: assert property (p_hold_man) else $error("holdover not from pin");
    property p_ref_man;
        (!ref_choice_pin_oe && $stable(ref_choice_pin_i))[*6] |-> active_ref_b == ref_choice_pin_i;
    endproperty
    a_ref_man: assert property (p_ref_man) else $error("reference not from pin");
    property p_oe_by_write;
        $changed({hold_pin_oe, ref_choice_pin_oe})
            |-> $past(wb_we_i && wb_ack_o) || $past(wb_we_i && wb_ack_o, 2);
    endproperty
    a_oe_by_write: assert property (p_oe_by_write) else $error("pin mode moved alone");
    // main scenarios reached
    c_hold: cover property ($rose(in_holdover));
    c_switch: cover property ($changed(active_ref_b));
    c_irq: cover property ($rose(irq));
endmodule : rsh_ctrl_chk

// ---- rsh_ctrl_test.sv ----
// self-checking bench for the switchover/holdover controller
`timescale 1ns/1ps
`include "rsh_map.svh"
module rsh_ctrl_test import rsh_pkg::*;;
    localparam logic [31:0] C_AREF = 32'h0000_0100;
    localparam logic [31:0] C_ROV = 32'h0000_0080;
    localparam logic [31:0] C_RF = 32'h0000_0040;
    localparam logic [31:0] C_AHLD = 32'h0000_0020;
    localparam logic [31:0] C_HOV = 32'h0000_0010;
    localparam logic [31:0] C_HF = 32'h0000_0008;
    localparam logic [31:0] C_LC = 32'h0000_0004;
    localparam logic [31:0] C_AENT = 32'h0000_0002;
    localparam logic [31:0] C_AEXT = 32'h0000_0001;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    rsh_mon_s mon = 4'h0;
    logic [47:0] loop_ftw = 48'h1111_2222_3333;
    logic ext_ref = 1'b0;
    logic ext_hold = 1'b0;
    logic run_a = 1'b0;
    logic run_b = 1'b0;
    logic reference_a_input;
    logic reference_b_input;
    logic ref_choice_pin_i;
    logic ref_choice_pin_o;
    logic ref_choice_pin_oe;
    logic hold_pin_i;
    logic hold_pin_o;
    logic hold_pin_oe;
    logic [47:0] dds_ftw;
    logic active_ref_b;
    logic in_holdover;
    logic irq;
    logic [31:0] rd;
    int err_count = 0;
    int tests_run = 0;
    int cyc_cnt = 0;
    // pin levels from the device enable: its output, else bench level
    assign ref_choice_pin_i = ref_choice_pin_oe ? ref_choice_pin_o : ext_ref;
    assign hold_pin_i = hold_pin_oe ? hold_pin_o : ext_hold;
    // clock
    always #5 sys_clk = ~sys_clk;
    rsh_ref_src u_rsh_ref_src (.sys_clk(sys_clk), .run_a(run_a), .run_b(run_b),
        .ref_a(reference_a_input), .ref_b(reference_b_input));
    rsh_ctrl u_rsh_ctrl (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mon(mon),
        .reference_a_input(reference_a_input), .reference_b_input(reference_b_input),
        .ref_choice_pin_i(ref_choice_pin_i), .ref_choice_pin_o(ref_choice_pin_o),
        .ref_choice_pin_oe(ref_choice_pin_oe), .hold_pin_i(hold_pin_i),
        .hold_pin_o(hold_pin_o), .hold_pin_oe(hold_pin_oe), .loop_ftw(loop_ftw),
        .dds_ftw(dds_ftw), .active_ref_b(active_ref_b), .in_holdover(in_holdover), .irq(irq));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one classic wishbone cycle, read data kept in rd
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1)
            @(posedge sys_clk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        wb_sel_i <= 4'h0;
    endtask : wb
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wt
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    // hang guard
    always @(posedge sys_clk)
    begin
        cyc_cnt++;
        if (cyc_cnt == 5000)
        begin
            err_count++;
            final_report;
        end
    end
    // test sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        wb(1'b0, `RSH_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, `RSH_ADDR_STAT, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        // manual pins, references stopped
        ext_ref <= 1'b1;
        wt(10);
        chk(active_ref_b, 1'b1);
        chk(ref_choice_pin_oe, 1'b0);
        ext_ref <= 1'b0;
        ext_hold <= 1'b1;
        wt(10);
        chk(in_holdover, 1'b1);
        chk(hold_pin_oe, 1'b0);
        chk(active_ref_b, 1'b0);
        wb(1'b1, `RSH_ADDR_FTW, 32'hCAFE_0001);
        wt(4);
        chk(dds_ftw, 48'h1111_CAFE_0001);
        ext_hold <= 1'b0;
        wt(10);
        chk(in_holdover, 1'b0);
        chk(dds_ftw, loop_ftw);
        // forced choice in line card mode waits for an edge of b
        mon <= 4'h3;
        wb(1'b1, `RSH_ADDR_MASK, 32'hF);
        wb(1'b1, `RSH_ADDR_CTRL, C_AREF | C_ROV | C_RF | C_LC);
        wb(1'b0, `RSH_ADDR_CTRL, 32'h0);
        chk(rd, C_AREF | C_ROV | C_RF | C_LC);
        wt(20);
        chk(active_ref_b, 1'b0);
        run_a <= 1'b1;
        run_b <= 1'b1;
        for (int i = 0; i < 60 && active_ref_b !== 1'b1; i++)
            @(posedge sys_clk);
        chk(active_ref_b, 1'b1);
        chk(ref_choice_pin_o, 1'b0);
        chk(ref_choice_pin_oe, 1'b1);
        run_b <= 1'b0;
        wb(1'b1, `RSH_ADDR_CTRL, C_AREF);
        wt(10);
        chk(active_ref_b, 1'b0);
        wb(1'b0, `RSH_ADDR_IRQ, 32'h0);
        // failures: switch to b, then holdover
        wb(1'b1, `RSH_ADDR_CTRL, C_AREF | C_AHLD | C_AENT);
        mon <= 4'h9;
        wt(10);
        chk(active_ref_b, 1'b1);
        chk(ref_choice_pin_o, 1'b1);
        chk(in_holdover, 1'b0);
        mon <= 4'hC;
        wt(10);
        chk(in_holdover, 1'b1);
        chk(hold_pin_o, 1'b1);
        chk(hold_pin_oe, 1'b1);
        wb(1'b0, `RSH_ADDR_STAT, 32'h0);
        chk(rd, 32'h3F);
        chk(irq, 1'b1);
        wb(1'b0, `RSH_ADDR_IRQ, 32'h0);
        chk(rd, 32'hB);
        wt(2);
        chk(irq, 1'b0);
        loop_ftw <= 48'h4444_5555_6666;
        wt(4);
        chk(dds_ftw, 48'h1111_2222_3333);
        // register override of the holdover decision
        wb(1'b1, `RSH_ADDR_MASK, 32'h0);
        wb(1'b1, `RSH_ADDR_CTRL, C_AREF | C_AHLD | C_AENT | C_HOV);
        wt(10);
        chk(in_holdover, 1'b0);
        chk(hold_pin_o, 1'b1);
        chk(dds_ftw, 48'h4444_5555_6666);
        chk(irq, 1'b0);
        wb(1'b0, `RSH_ADDR_IRQ, 32'h0);
        chk(rd, 32'h4);
        wb(1'b1, `RSH_ADDR_CTRL, C_AREF | C_AHLD | C_AENT | C_HOV | C_HF);
        wt(10);
        chk(in_holdover, 1'b1);
        // automatic exit only once a reference is validated again
        wb(1'b1, `RSH_ADDR_CTRL, C_AREF | C_AHLD | C_AENT | C_AEXT);
        wt(10);
        chk(in_holdover, 1'b1);
        mon <= 4'h1;
        wt(10);
        chk(in_holdover, 1'b0);
        chk(active_ref_b, 1'b1);
        chk(hold_pin_o, 1'b0);
        chk(dds_ftw, 48'h4444_5555_6666);
        final_report;
    end
endmodule : rsh_ctrl_test
bind rsh_ctrl rsh_ctrl_chk #(.FTW_W(FTW_W)) u_rsh_ctrl_chk (.sys_clk(sys_clk), .rst(rst),
    .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .ref_choice_pin_i(ref_choice_pin_i), .ref_choice_pin_oe(ref_choice_pin_oe),
    .hold_pin_i(hold_pin_i), .hold_pin_oe(hold_pin_oe), .loop_ftw(loop_ftw),
    .dds_ftw(dds_ftw), .active_ref_b(active_ref_b), .in_holdover(in_holdover), .irq(irq));
